// >>> hsc_pkg.sv
/*
  Package for the homing sequencer: configuration word layout, method codes,
  state encoding and carrier structs.
  Assumes one drive clock domain and a synchronous active-high reset.
*/
package hsc_pkg;
  // ==========================================================
  // configuration word layout
  localparam int HSC_CFG_W = 16;
  localparam int HSC_POS_W = 32;
  localparam int HSC_METHOD_LSB = 0;
  localparam int HSC_METHOD_MSB = 3;
  localparam int HSC_BIT_DIR = 4;
  localparam int HSC_BIT_INDEX = 5;
  localparam int HSC_BIT_IDX_SIDE = 6;
  localparam int HSC_BIT_IDX_FALL = 7;
  localparam int HSC_BIT_SW_NEG = 8;
  localparam int HSC_BIT_MOVE_ZERO = 9;
  localparam int HSC_BIT_NO_ADJUST = 10;
  localparam logic [HSC_CFG_W-1:0] HSC_CFG_RESET = 16'h0000;

  // ==========================================================
  // method codes
  localparam logic [3:0] HSC_M_HERE = 4'h0;
  localparam logic [3:0] HSC_M_LIMIT = 4'h1;
  localparam logic [3:0] HSC_M_CONST_SW = 4'h2;
  localparam logic [3:0] HSC_M_INTER_SW = 4'h3;
  localparam logic [3:0] HSC_M_HARD_STOP = 4'h4;
  localparam logic [3:0] HSC_M_IMMEDIATE = 4'hf;

  // ==========================================================
  // timing
  localparam int HSC_CLK_MHZ = 100;
  localparam int HSC_DELAY_MS = 250;
  localparam int HSC_DELAY_CYC = HSC_DELAY_MS * 1000 * HSC_CLK_MHZ;

  // ==========================================================
  // states, one-hot
  typedef enum logic [8:0] {
    HSC_IDLE   = 9'h001,
    HSC_SEARCH = 9'h002,
    HSC_BACK   = 9'h004,
    HSC_INDEX  = 9'h008,
    HSC_PRESS  = 9'h010,
    HSC_LOAD   = 9'h020,
    HSC_ZERO   = 9'h040,
    HSC_DONE   = 9'h080,
    HSC_ERROR  = 9'h100
  } hsc_state_e;

  // motion command towards the trajectory generator
  typedef struct packed {
    logic run;
    logic neg;
    logic to_zero;
  } hsc_motion_s;

  // synchronised sensor inputs
  typedef struct packed {
    logic lim_pos;
    logic lim_neg;
    logic home_sw;
    logic index;
    logic over_cur;
  } hsc_sense_s;
endpackage

// >>> hsc_edge.sv
/*
  Two-flop synchroniser with edge detection on the resynchronised level.
  Assumes an asynchronous input and the drive clock.
*/
`timescale 1ns/1ps
module hsc_edge (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb begin
    next_meta = pin_i;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // edges are taken only between second and third stage
  assign level_o = sync;
  assign rise_o = sync & ~prev;
  assign fall_o = ~sync & prev;
endmodule // hsc_edge

// >>> hsc_homing.sv
/*
  Homing sequencer: runs the method held in the configuration word and
  produces motion commands and the referenced position.
  Assumes a trajectory generator that follows motion_o, raw pins for switches,
  index and over-current, and an encoder position on the drive clock.
*/
`timescale 1ns/1ps
module hsc_homing import hsc_pkg::*; #(
  parameter int DELAY_CYC = HSC_DELAY_CYC,
  parameter int POS_W = HSC_POS_W
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cfg_we_i,
  input wire logic [HSC_CFG_W-1:0] cfg_wdata_i,
  input wire logic start_i,
  input wire logic enc_ready_i,
  input wire logic [POS_W-1:0] enc_pos_i,
  input wire logic [POS_W-1:0] home_offset_i,
  input wire logic lim_pos_i,
  input wire logic lim_neg_i,
  input wire logic home_sw_i,
  input wire logic index_i,
  input wire logic over_cur_i,
  output logic [HSC_CFG_W-1:0] cfg_o,
  output hsc_motion_s motion_o,
  output logic pos_load_o,
  output logic [POS_W-1:0] pos_value_o,
  output logic [POS_W-1:0] adjust_o,
  output logic busy_o,
  output logic done_o,
  output logic err_limit_o,
  output logic err_cfg_o
);
  // ==========================================================
  // input synchronisers
  logic [4:0] raw;
  logic [4:0] lvl;
  logic [4:0] rise;
  logic [4:0] fall;
  hsc_sense_s s_lvl;
  hsc_sense_s s_rise;
  hsc_sense_s s_fall;

  assign raw = {lim_pos_i, lim_neg_i, home_sw_i, index_i, over_cur_i};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      hsc_edge u_edge (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(raw[gi]),
        .level_o(lvl[gi]),
        .rise_o(rise[gi]),
        .fall_o(fall[gi])
      );
    end
  endgenerate

  assign s_lvl = lvl;
  assign s_rise = rise;
  assign s_fall = fall;

  // ==========================================================
  // configuration decode
  logic [3:0] method;
  logic dir_neg;
  logic use_index;
  logic idx_same_side;
  logic idx_fall;
  logic sw_neg;
  logic move_zero;
  logic no_adjust;

  assign method = cfg_o[HSC_METHOD_MSB:HSC_METHOD_LSB];
  assign dir_neg = cfg_o[HSC_BIT_DIR];
  assign use_index = cfg_o[HSC_BIT_INDEX];
  assign idx_same_side = cfg_o[HSC_BIT_IDX_SIDE];
  assign idx_fall = cfg_o[HSC_BIT_IDX_FALL];
  assign sw_neg = cfg_o[HSC_BIT_SW_NEG];
  assign move_zero = cfg_o[HSC_BIT_MOVE_ZERO];
  assign no_adjust = cfg_o[HSC_BIT_NO_ADJUST];

  logic index_hit;
  logic sw_edge;
  logic limit_ahead;
  logic reserved;

  assign index_hit = idx_fall ? s_fall.index : s_rise.index;
  // a constant switch is always left on its falling edge; bit 8 only picks the edge of the momentary switch
  assign sw_edge = (method == HSC_M_INTER_SW && !sw_neg) ? s_rise.home_sw : s_fall.home_sw;
  assign limit_ahead = motion_o.neg ? s_lvl.lim_neg : s_lvl.lim_pos;
  assign reserved = (method > HSC_M_HARD_STOP) && (method != HSC_M_IMMEDIATE);

  // ==========================================================
  // sequencer
  hsc_state_e state;
  hsc_state_e next_state;
  hsc_motion_s next_motion;
  logic [HSC_CFG_W-1:0] next_cfg;
  logic next_pos_load;
  logic [POS_W-1:0] next_pos_value;
  logic [POS_W-1:0] next_adjust;
  logic next_busy;
  logic next_done;
  logic next_err_limit;
  logic next_err_cfg;
  logic [31:0] dly;
  logic [31:0] next_dly;
  logic pwr_pending;
  logic next_pwr_pending;
  logic skip_idx;
  logic next_skip_idx;
  logic [POS_W-1:0] home_pos;

  // new position = offset at the home point; correction is its difference
  assign home_pos = home_offset_i;

  always_comb begin
    next_state = state;
    next_motion = motion_o;
    next_cfg = cfg_o;
    next_pos_load = 1'b0;
    next_pos_value = pos_value_o;
    next_adjust = adjust_o;
    next_busy = busy_o;
    next_done = done_o;
    next_err_limit = err_limit_o;
    next_err_cfg = err_cfg_o;
    next_dly = dly;
    next_pwr_pending = pwr_pending;
    next_skip_idx = skip_idx;
    if (cfg_we_i && (state == HSC_IDLE || state == HSC_DONE || state == HSC_ERROR)) begin
      next_cfg = cfg_wdata_i;
    end
    // immediate method waits only for the encoder, not for a start
    if (pwr_pending && enc_ready_i) begin
      next_pwr_pending = 1'b0;
      if (method == HSC_M_IMMEDIATE) begin
        next_pos_load = 1'b1;
        next_pos_value = enc_pos_i + home_offset_i;
        next_done = 1'b1;
      end
    end
    case (state)
      HSC_IDLE, HSC_DONE, HSC_ERROR: begin
        if (start_i) begin
          next_done = 1'b0;
          next_err_limit = 1'b0;
          next_err_cfg = 1'b0;
          next_motion.to_zero = 1'b0;
          next_motion.neg = dir_neg;
          next_skip_idx = 1'b0;
          if (reserved) begin
            next_err_cfg = 1'b1;
            next_state = HSC_ERROR;
          end else if (method == HSC_M_IMMEDIATE) begin
            next_pos_load = 1'b1;
            next_pos_value = enc_pos_i + home_offset_i;
            next_done = 1'b1;
            next_state = HSC_DONE;
          end else if (method == HSC_M_HERE && !use_index) begin
            next_state = HSC_LOAD;
          end else if (method == HSC_M_HERE) begin
            next_motion.run = 1'b1;
            next_busy = 1'b1;
            next_state = HSC_INDEX;
          end else begin
            next_motion.run = 1'b1;
            next_busy = 1'b1;
            next_state = HSC_SEARCH;
          end
        end
      end
      HSC_SEARCH: begin
        if (method == HSC_M_HARD_STOP) begin
          if (s_lvl.over_cur) begin
            next_dly = 32'h0000_0000;
            next_state = HSC_PRESS;
          end
        end else if (method == HSC_M_LIMIT) begin
          if (limit_ahead) begin
            next_motion.neg = ~motion_o.neg;
            next_state = HSC_BACK;
          end
        end else if (s_lvl.home_sw) begin
          next_motion.neg = ~motion_o.neg;
          // pulse on the initial side was already passed; count one back
          next_skip_idx = idx_same_side;
          next_state = HSC_BACK;
        end else if (limit_ahead) begin
          if (method == HSC_M_INTER_SW) begin
            next_motion.neg = ~motion_o.neg;
          end else begin
            next_motion.run = 1'b0;
            next_busy = 1'b0;
            next_err_limit = 1'b1;
            next_state = HSC_ERROR;
          end
        end
      end
      HSC_BACK: begin
        // leaving the limit, or the selected edge of the switch: that edge is the reference
        if ((method == HSC_M_LIMIT) ? !limit_ahead && !s_lvl.lim_pos && !s_lvl.lim_neg : sw_edge) begin
          next_state = use_index ? HSC_INDEX : HSC_LOAD;
          next_motion.run = use_index;
        end else if (method == HSC_M_INTER_SW && !sw_neg && s_fall.home_sw) begin
          // rising edge wanted but the axis is leaving the switch: turn and run back onto it
          next_motion.neg = ~motion_o.neg;
        end
      end
      HSC_PRESS: begin
        // drive holds current at the threshold while run stays set
        if (dly >= DELAY_CYC - 1) begin
          if (use_index) begin
            next_motion.neg = ~motion_o.neg;
            next_state = HSC_INDEX;
          end else begin
            next_motion.run = 1'b0;
            next_state = HSC_LOAD;
          end
        end else begin
          next_dly = dly + 32'h0000_0001;
        end
      end
      HSC_INDEX: begin
        if (index_hit) begin
          if (skip_idx) begin
            next_skip_idx = 1'b0;
          end else begin
            next_motion.run = 1'b0;
            next_state = HSC_LOAD;
          end
        end
      end
      HSC_LOAD: begin
        next_motion.run = 1'b0;
        next_adjust = home_pos - enc_pos_i;
        if (!no_adjust) begin
          next_pos_load = 1'b1;
          next_pos_value = home_pos;
        end
        if (move_zero && !no_adjust) begin
          next_motion.to_zero = 1'b1;
          next_motion.run = 1'b1;
          next_state = HSC_ZERO;
        end else begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = HSC_DONE;
        end
      end
      HSC_ZERO: begin
        // one-cycle move request to the trajectory generator
        next_motion.run = 1'b0;
        next_motion.to_zero = 1'b0;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = HSC_DONE;
      end
      default: begin
        next_state = HSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= HSC_IDLE;
      motion_o <= '0;
      cfg_o <= HSC_CFG_RESET;
      pos_load_o <= 1'b0;
      pos_value_o <= '0;
      adjust_o <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      err_limit_o <= 1'b0;
      err_cfg_o <= 1'b0;
      dly <= 32'h0000_0000;
      pwr_pending <= 1'b1;
      skip_idx <= 1'b0;
    end else begin
      state <= next_state;
      motion_o <= next_motion;
      cfg_o <= next_cfg;
      pos_load_o <= next_pos_load;
      pos_value_o <= next_pos_value;
      adjust_o <= next_adjust;
      busy_o <= next_busy;
      done_o <= next_done;
      err_limit_o <= next_err_limit;
      err_cfg_o <= next_err_cfg;
      dly <= next_dly;
      pwr_pending <= next_pwr_pending;
      skip_idx <= next_skip_idx;
    end
  end
endmodule // hsc_homing

// >>> hsc_homing_checker.sv
/*
  Concurrent checks on the ports of the homing sequencer.
  Assumes it is bound into every hsc_homing instance, one clock domain.
*/
`timescale 1ns/1ps
module hsc_homing_checker import hsc_pkg::*; #(
  parameter int DELAY_CYC = HSC_DELAY_CYC,
  parameter int POS_W = HSC_POS_W
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cfg_we_i,
  input wire logic [HSC_CFG_W-1:0] cfg_wdata_i,
  input wire logic start_i,
  input wire logic enc_ready_i,
  input wire logic [POS_W-1:0] enc_pos_i,
  input wire logic [POS_W-1:0] home_offset_i,
  input wire logic lim_pos_i,
  input wire logic lim_neg_i,
  input wire logic home_sw_i,
  input wire logic index_i,
  input wire logic over_cur_i,
  input wire logic [HSC_CFG_W-1:0] cfg_o,
  input wire hsc_motion_s motion_o,
  input wire logic pos_load_o,
  input wire logic [POS_W-1:0] pos_value_o,
  input wire logic [POS_W-1:0] adjust_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic err_limit_o,
  input wire logic err_cfg_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ==========================================================
  // press time counter
  // pin cycles bound the synchronised count from above, so >= is safe
  int press_cnt;
  int next_press_cnt;
  always_comb begin
    next_press_cnt = press_cnt;
    if (start_i && !busy_o) next_press_cnt = 0;
    else if (busy_o && over_cur_i && press_cnt < DELAY_CYC) next_press_cnt = press_cnt + 1;
  end
  always_ff @(posedge clk_i) begin
    press_cnt <= sys_rst_i ? 0 : next_press_cnt;
  end

  // ==========================================================
  // properties
  sequence s_go;
    start_i && !busy_o && !cfg_we_i;
  endsequence
  sequence s_finish;
    $rose(done_o);
  endsequence

  chk_cfg_refuse: assert property (s_go ##0 (cfg_o[3:0] inside {[4'h5:4'he]})
    |=> (err_cfg_o && !motion_o.run) [*2]) else $error("reserved method not refused");
  chk_start_dir: assert property (s_go ##0 (cfg_o[3:0] inside {4'h2, 4'h3, 4'h4})
    |=> motion_o.run && motion_o.neg == cfg_o[HSC_BIT_DIR]) else $error("wrong initial move");
  chk_imm_load: assert property (s_go ##0 (cfg_o[3:0] == HSC_M_IMMEDIATE && enc_ready_i && !cfg_o[10])
    |=> pos_load_o && pos_value_o == $past(enc_pos_i) + $past(home_offset_i)) else $error("bad immediate home");
  chk_quiet_pos: assert property (s_finish ##0 (cfg_o[HSC_BIT_NO_ADJUST] && cfg_o[3:0] != HSC_M_IMMEDIATE)
    |-> !pos_load_o) else $error("position adjusted despite suppression");
  chk_zero_gate: assert property (motion_o.to_zero
    |-> cfg_o[HSC_BIT_MOVE_ZERO] && !cfg_o[HSC_BIT_NO_ADJUST]) else $error("unexpected move to zero");
  chk_zero_move: assert property (pos_load_o && cfg_o[9] && !cfg_o[10] && cfg_o[3:0] != 4'hf
    |-> ##[0:2] motion_o.to_zero) else $error("move to zero missing");
  chk_limit_err: assert property ($rose(err_limit_o)
    |-> cfg_o[3:0] == HSC_M_CONST_SW && !motion_o.run) else $error("limit error in wrong method");
  chk_press_time: assert property (s_finish ##0 (cfg_o[3:0] == HSC_M_HARD_STOP)
    |-> press_cnt >= DELAY_CYC) else $error("hard stop left before delay");
  chk_load_ref: assert property (pos_load_o && cfg_o[3:0] != HSC_M_IMMEDIATE
    |-> pos_value_o == home_offset_i) else $error("home reference not offset");
endmodule // hsc_homing_checker

bind hsc_homing hsc_homing_checker #(.DELAY_CYC(DELAY_CYC), .POS_W(POS_W)) i_chk (.*);

// >>> hsc_plant.sv
/*
  Axis model: one count per cycle while run, hard stops at +-64.
  Assumes motion commands from the sequencer on the same clock.
*/
`timescale 1ns/1ps
module hsc_plant import hsc_pkg::*; (
  input wire logic clk_i,
  input wire logic place_i,
  input wire hsc_motion_s motion_i,
  output logic [HSC_POS_W-1:0] enc_pos_o,
  output logic lim_pos_o,
  output logic lim_neg_o,
  output logic home_sw_o,
  output logic index_o,
  output logic over_cur_o
);
  int pos = 0;
  // ==========================================================
  // axis travel, stopped by the mechanical ends
  always @(posedge clk_i) begin
    if (place_i) pos <= 0;
    else if (motion_i.run && !(motion_i.neg ? pos <= -64 : pos >= 64)) pos <= pos + (motion_i.neg ? -1 : 1);
  end
  assign enc_pos_o = 32'(pos);
  assign lim_pos_o = pos >= 60;
  assign lim_neg_o = pos <= -60;
  assign home_sw_o = pos >= 20 && pos <= 40;
  assign index_o = pos[3:0] == 4'h0;
  // pressing against an end drives current over the threshold
  assign over_cur_o = pos >= 64 || pos <= -64;
endmodule // hsc_plant

// >>> hsc_homing_tb.sv
/*
  Self-checking bench for the homing sequencer with an axis model.
  Assumes a short homing delay parameter and the bound checker.
*/
`timescale 1ns/1ps
module hsc_homing_tb import hsc_pkg::*;;
  localparam int DLY = 20;
  logic clk_i = 0;
  logic sys_rst_i = 1;
  logic cfg_we_i = 0;
  logic [15:0] cfg_wdata_i = 16'h0000;
  logic start_i = 0;
  logic enc_ready_i = 0;
  logic place_i = 0;
  logic [31:0] home_offset_i = 32'h0000_0100;
  logic [31:0] enc_pos_i;
  logic lim_pos_i, lim_neg_i, home_sw_i, index_i, over_cur_i;
  logic [15:0] cfg_o;
  hsc_motion_s motion_o;
  logic pos_load_o, busy_o, done_o, err_limit_o, err_cfg_o;
  logic [31:0] pos_value_o, adjust_o;
  logic [15:0] w;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_load = 0;
  int load_base = 0;

  always #5 clk_i = ~clk_i;
  hsc_homing #(.DELAY_CYC(DLY)) i_dut (.*);
  hsc_plant i_plant (.clk_i(clk_i), .place_i(place_i), .motion_i(motion_o), .enc_pos_o(enc_pos_i),
    .lim_pos_o(lim_pos_i), .lim_neg_o(lim_neg_i), .home_sw_o(home_sw_i), .index_o(index_i),
    .over_cur_o(over_cur_i));

  // ==========================================================
  // helpers
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (pos_load_o === 1'b1) n_load <= n_load + 1;
    if (cyc == 40000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  // returns the axis to the origin between runs
  task automatic place();
    @(posedge clk_i) place_i <= 1;
    @(posedge clk_i) place_i <= 0;
  endtask

  task automatic run_home(logic [15:0] cw);
    int n;
    n = 0;
    load_base = n_load;
    @(posedge clk_i) cfg_we_i <= 1;
    cfg_wdata_i <= cw;
    @(posedge clk_i) cfg_we_i <= 0;
    start_i <= 1;
    @(posedge clk_i) start_i <= 0;
    @(negedge clk_i);
    while (!(done_o === 1'b1 || err_limit_o === 1'b1 || err_cfg_o === 1'b1) && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    chk("finish", 1, 32'(n < 3000));
    repeat (4) @(negedge clk_i);
  endtask

  task automatic close_out();
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'h2afb));
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 0;
    enc_ready_i <= 1;
    @(negedge clk_i) chk("cfg_reset", 32'(HSC_CFG_RESET), 32'(cfg_o));
    for (int m = 5; m < 15; m++) begin
      run_home(16'(m));
      chk("err_cfg", 1, 32'(err_cfg_o));
      chk("cfg_o", 32'(m), 32'(cfg_o));
    end
    run_home(16'h0000);
    chk("adjust", home_offset_i - enc_pos_i, adjust_o);
    chk("loads", 1, 32'(n_load - load_base));
    run_home(16'h0400);
    chk("loads", 0, 32'(n_load - load_base));
    chk("adjust", home_offset_i - enc_pos_i, adjust_o);
    run_home(16'h0200);
    run_home(16'h0600);
    run_home(16'h000f);
    chk("imm_pos", enc_pos_i + home_offset_i, pos_value_o);
    place();
    run_home(16'h0002);
    chk("done", 1, 32'(done_o));
    chk("pos_value", home_offset_i, pos_value_o);
    place();
    run_home(16'h0012);
    chk("err_limit", 1, 32'(err_limit_o));
    place();
    run_home(16'h0013);
    chk("done", 1, 32'(done_o));
    place();
    run_home(16'h0014);
    chk("done", 1, 32'(done_o));
    place();
    run_home(16'h0024);
    chk("done", 1, 32'(done_o));
    for (int i = 0; i < 12; i++) begin
      w = {5'h00, 7'($urandom), 4'h0};
      w[3:0] = (i % 3 == 0) ? HSC_M_LIMIT : (i % 3 == 1) ? HSC_M_INTER_SW : HSC_M_HARD_STOP;
      home_offset_i <= $urandom;
      place();
      run_home(w);
      chk("done", 1, 32'(done_o));
      chk("loads", 32'(!w[10]), 32'(n_load - load_base));
    end
    // power-up referencing: a second reset with the encoder not yet ready
    @(posedge clk_i) sys_rst_i <= 1;
    enc_ready_i <= 0;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 0;
    cfg_we_i <= 1;
    cfg_wdata_i <= 16'h000f;
    @(posedge clk_i) cfg_we_i <= 0;
    load_base = n_load;
    @(posedge clk_i) enc_ready_i <= 1;
    repeat (4) @(negedge clk_i);
    chk("pwr_loads", 1, 32'(n_load - load_base));
    chk("pwr_pos", enc_pos_i + home_offset_i, pos_value_o);
    chk("pwr_done", 1, 32'(done_o));
    close_out();
  end
endmodule // hsc_homing_tb
